/* src/oms_top.sv */
// Output mode selection and timed maintenance check sequencer
// Summary of operation
// R01 - Mode plus highest-priority operating state selects outputs
// R02 - Init: relays, serious, noise off; minor fast
// R03 - Standby normal: minor slow blink, relays follow hold
// R04 - Noise protection: noise output on, noise relays
// R05 - Serious failure: relays off, 3.5 mA, serious on
// R06 - Maintenance: sequence drives all outputs
// R07 - Failure outputs active high; minor shared present
// R08 - Enter maintenance on 2 s hold or request
// R09 - Phase 1: minor slow blink, analog 20 mA
// R10 - Phase 1: serious on after 1 s
// R11 - Phase 1: relay on after another 1 s
// R12 - Accelerometer diagnosis starts 30 s after entry
// R13 - Diagnosis done: flash, serious off, 4 mA, liquefaction
// R14 - Phase 2 on hold/request: 12 mA, relay1 off
// R15 - Phase 2: serious on after 1 s
// R16 - Phase 2: relay 2 on after another 1 s
// R17 - Phase 2 end after 28 s: flash, 4 mA
// R18 - Hold counter restarts when input drops early
// R19 - Blink periods are parameters with documented defaults
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "oms_regs.svh"

module oms_top #(
  parameter int unsigned TICK_CYCLES   = `OMS_TICK_CYC,
  parameter int unsigned HOLD_MS       = `OMS_T_HOLD_MS,
  parameter int unsigned STEP_MS       = `OMS_T_STEP_MS,
  parameter int unsigned DIAG_MS       = `OMS_T_DIAG_MS,
  parameter int unsigned P2_RUN_MS     = `OMS_T_P2_RUN_MS,
  parameter int unsigned FAST_HALF_MS  = `OMS_T_FAST_MS,
  parameter int unsigned SLOW_HALF_MS  = `OMS_T_SLOW_MS,
  parameter int unsigned MSLOW_HALF_MS = `OMS_T_MSLOW_MS,
  parameter int unsigned FLASH_HALF_MS = `OMS_T_FLASH_MS
) (
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_RST,
  input  wire logic [`OMS_ADDR_W-1:0] I_ADDR,
  input  wire logic [31:0]            I_WDATA,
  input  wire logic                   I_WR,
  input  wire logic                   I_RD,
  output logic      [31:0]            O_RDATA,
  input  wire logic                   I_DIAGNOSIS_INPUT,
  input  wire logic                   I_MINOR_FAIL,
  input  wire logic                   I_SERIOUS_FAIL,
  input  wire logic                   I_NOISE_ACTIVE,
  input  wire logic [2:0]             I_HOLD_RELAY,
  input  wire logic [2:0]             I_NOISE_RELAY,
  input  wire logic [`OMS_AO_W-1:0]   I_PV_A,
  input  wire logic [`OMS_AO_W-1:0]   I_PV_B,
  input  wire logic                   I_ACCEL_DIAG_DONE,
  output logic      [2:0]             O_RELAY,
  output logic                        O_MINOR_FAILURE_OUTPUT,
  output logic                        O_SERIOUS_FAILURE_OUTPUT,
  output logic                        O_NOISE_PROTECTION_OUTPUT,
  output logic                        O_LIQUEFACTION_OUTPUT,
  output logic      [`OMS_AO_W-1:0]   O_ANALOG_OUTPUT_A,
  output logic      [`OMS_AO_W-1:0]   O_ANALOG_OUTPUT_B,
  output logic                        O_ACCEL_DIAG_START,
  output logic                        O_IRQ
);
  import oms_pkg::*;

  oms_state_t r;
  oms_state_t next_r;

  // Advance a millisecond counter that wraps at the given length
  function automatic logic [15:0] ms_step(input logic [15:0] cnt,
                                          input int unsigned len,
                                          input logic tick);
    logic [15:0] res;
    res = cnt;
    if (tick) begin
      if (cnt >= 16'(len - 1)) begin
        res = 16'h0000;
      end else begin
        res = cnt + 16'h0001;
      end
    end
    return res;
  endfunction

  // True on the tick that completes the given length
  function automatic logic ms_hit(input logic [15:0] cnt,
                                  input int unsigned len,
                                  input logic tick);
    return tick && (cnt >= 16'(len - 1));
  endfunction

  // Register strobes decoded once; each is a single-cycle pulse
  logic       wr_mode;
  logic       wr_req;
  logic       wr_clr;
  logic       wr_en;
  logic       req_mode;
  logic       req_phase;
  logic       hold_evt;
  logic [4:0] evt;

  always_comb begin
    wr_mode   = I_WR && (I_ADDR == `OMS_REG_MODE);
    wr_req    = I_WR && (I_ADDR == `OMS_REG_REQ);
    wr_clr    = I_WR && (I_ADDR == `OMS_REG_IRQ_CLR);
    wr_en     = I_WR && (I_ADDR == `OMS_REG_IRQ_EN);
    req_mode  = wr_req && I_WDATA[`OMS_REQ_MODE_BIT];
    req_phase = wr_req && I_WDATA[`OMS_REQ_PHASE_BIT];
    hold_evt  = 1'b0;
    evt       = 5'h00;
    next_r    = r;

    // Millisecond time base
    // Every timer below advances only on this tick, so phase lengths
    // are counted in whole ticks and may end up to one tick early
    next_r.tick = 1'b0;
    if (r.tick_cnt >= 20'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = 20'h00000;
      next_r.tick     = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 20'h00001;
    end

    // Blink generators, each toggling every half period
    next_r.fast_ms  = ms_step(r.fast_ms, FAST_HALF_MS, r.tick); // [R19]
    next_r.slow_ms  = ms_step(r.slow_ms, SLOW_HALF_MS, r.tick);
    next_r.mslow_ms = ms_step(r.mslow_ms, MSLOW_HALF_MS, r.tick);
    next_r.flash_ms = ms_step(r.flash_ms, FLASH_HALF_MS, r.tick);
    if (ms_hit(r.fast_ms, FAST_HALF_MS, r.tick)) begin
      next_r.fast_blk = !r.fast_blk;
    end
    if (ms_hit(r.slow_ms, SLOW_HALF_MS, r.tick)) begin
      next_r.slow_blk = !r.slow_blk;
    end
    if (ms_hit(r.mslow_ms, MSLOW_HALF_MS, r.tick)) begin
      next_r.mslow_blk = !r.mslow_blk;
    end
    if (ms_hit(r.flash_ms, FLASH_HALF_MS, r.tick)) begin
      next_r.flash_blk = !r.flash_blk;
    end

    // Diagnosis input hold qualifier; one event per assertion
    // The count restarts on any low, so a bouncing contact never
    // qualifies on time gathered over several presses
    if (!I_DIAGNOSIS_INPUT) begin
      next_r.hold_ms   = 16'h0000; // [R18]
      next_r.hold_wait = 1'b0;
    end else if (!r.hold_wait && r.tick) begin
      if (r.hold_ms >= 16'(HOLD_MS - 1)) begin
        hold_evt         = 1'b1;
        next_r.hold_wait = 1'b1;
        next_r.hold_ms   = 16'h0000;
      end else begin
        next_r.hold_ms = r.hold_ms + 16'h0001;
      end
    end

    // Software mode selection; maintenance is only entered by hold or request
    if (wr_mode && (r.mode != MODE_MAINT) &&
        (oms_mode_t'(I_WDATA[1:0]) != MODE_MAINT)) begin
      next_r.mode = oms_mode_t'(I_WDATA[1:0]);
    end

    next_r.diag_start = 1'b0;
    // Free-running step counter; the timed states SEQ_P1_A, SEQ_P1_B, SEQ_P1_C, SEQ_P2_A, SEQ_P2_B and SEQ_P2_C clear it on entry
    next_r.step_ms    = ms_step(r.step_ms, 16'hFFFF, r.tick);

    case (r.seq)
      SEQ_IDLE: begin
        if ((r.mode == MODE_MEAS) && (hold_evt || req_mode)) begin // [R08]
          next_r.mode         = MODE_MAINT;
          next_r.seq          = SEQ_P1_A;
          next_r.step_ms      = 16'h0000;
          next_r.maint_ms     = 16'h0000;
          next_r.diag_started = 1'b0;
          evt[`OMS_IRQ_MAINT] = 1'b1;
        end
      end
      SEQ_P1_A: begin
        if (ms_hit(r.step_ms, STEP_MS, r.tick)) begin // [R10]
          next_r.seq     = SEQ_P1_B;
          next_r.step_ms = 16'h0000;
        end
      end
      SEQ_P1_B: begin
        if (ms_hit(r.step_ms, STEP_MS, r.tick)) begin // [R11]
          next_r.seq     = SEQ_P1_C;
          next_r.step_ms = 16'h0000;
        end
      end
      SEQ_P1_C: begin
        // A done pulse before the diagnosis was started is ignored
        if (r.diag_started && I_ACCEL_DIAG_DONE) begin // [R13]
          next_r.seq              = SEQ_P1_END;
          evt[`OMS_IRQ_STEP_DONE] = 1'b1;
        end
      end
      SEQ_P1_END: begin
        if (hold_evt || req_phase) begin // [R14]
          next_r.seq           = SEQ_P2_A;
          next_r.step_ms       = 16'h0000;
          evt[`OMS_IRQ_PHASE2] = 1'b1;
        end
      end
      SEQ_P2_A: begin
        if (ms_hit(r.step_ms, STEP_MS, r.tick)) begin // [R15]
          next_r.seq     = SEQ_P2_B;
          next_r.step_ms = 16'h0000;
        end
      end
      SEQ_P2_B: begin
        if (ms_hit(r.step_ms, STEP_MS, r.tick)) begin // [R16]
          next_r.seq     = SEQ_P2_C;
          next_r.step_ms = 16'h0000;
        end
      end
      SEQ_P2_C: begin
        if (ms_hit(r.step_ms, P2_RUN_MS, r.tick)) begin // [R17]
          next_r.seq              = SEQ_P2_END;
          evt[`OMS_IRQ_STEP_DONE] = 1'b1;
        end
      end
      SEQ_P2_END: begin
        // Later phases are not built; a request ends maintenance here
        if (hold_evt || req_mode) begin
          next_r.seq  = SEQ_IDLE;
          next_r.mode = MODE_INIT;
        end
      end
      default: begin
        next_r.seq  = SEQ_IDLE;
        next_r.mode = MODE_INIT;
      end
    endcase

    // Accelerometer diagnosis start, timed from maintenance entry
    if ((r.mode == MODE_MAINT) && !r.diag_started && r.tick) begin
      if (r.maint_ms >= 16'(DIAG_MS - 1)) begin
        next_r.diag_start    = 1'b1; // [R12]
        next_r.diag_started  = 1'b1;
        evt[`OMS_IRQ_DIAG]   = 1'b1;
      end else begin
        next_r.maint_ms = r.maint_ms + 16'h0001;
      end
    end

    next_r.serious_d = I_SERIOUS_FAIL;
    evt[`OMS_IRQ_SERIOUS] = I_SERIOUS_FAIL && !r.serious_d;

    // Output selection: later operating states override earlier ones
    // Outputs follow the state inputs one edge later; the priority is
    // serious over noise over minor over normal operation
    next_r.relay   = 3'b000;
    next_r.minor   = 1'b0;
    next_r.serious = 1'b0;
    next_r.noise   = 1'b0;
    next_r.liq     = 1'b0;
    next_r.ao_a    = `OMS_AO_ZERO;
    next_r.ao_b    = `OMS_AO_ZERO;
    case (r.mode)
      MODE_INIT: begin
        next_r.minor = r.fast_blk; // [R02]
      end
      MODE_MEAS, MODE_STANDBY: begin
        next_r.relay = I_HOLD_RELAY;
        next_r.ao_a  = I_PV_A;
        next_r.ao_b  = I_PV_B;
        // Standby shows power presence by blinking the shared output
        next_r.minor = (r.mode == MODE_STANDBY) ? r.slow_blk : 1'b0; // [R03]
        if (I_MINOR_FAIL) begin // [R01]
          next_r.minor = 1'b1; // [R07]
        end
        if (I_NOISE_ACTIVE) begin
          next_r.noise = 1'b1; // [R04]
          next_r.relay = I_NOISE_RELAY;
        end
        if (I_SERIOUS_FAIL) begin // [R05]
          next_r.relay   = 3'b000;
          next_r.ao_a    = `OMS_AO_FAULT;
          next_r.ao_b    = `OMS_AO_FAULT;
          next_r.serious = 1'b1;
          next_r.noise   = 1'b0;
          next_r.minor   = 1'b1;
        end
      end
      // Relay bit 0 is relay 1; phase 2 drives relay 2 only
      MODE_MAINT: begin // [R06]
        case (r.seq)
          SEQ_P1_A, SEQ_P1_B, SEQ_P1_C: begin
            next_r.minor   = r.mslow_blk; // [R09]
            next_r.ao_a    = `OMS_AO_FULL;
            next_r.ao_b    = `OMS_AO_FULL;
            next_r.serious = (r.seq != SEQ_P1_A); // [R10]
            next_r.relay   = {2'b00, r.seq == SEQ_P1_C}; // [R11]
          end
          SEQ_P1_END: begin
            next_r.minor = r.flash_blk; // [R13]
            next_r.liq   = r.mslow_blk;
            next_r.relay = 3'b001;
          end
          SEQ_P2_A, SEQ_P2_B, SEQ_P2_C: begin
            next_r.minor   = r.mslow_blk; // [R14]
            next_r.ao_a    = `OMS_AO_HALF;
            next_r.ao_b    = `OMS_AO_HALF;
            next_r.serious = (r.seq != SEQ_P2_A); // [R15]
            next_r.relay   = {1'b0, r.seq == SEQ_P2_C, 1'b0}; // [R16]
          end
          SEQ_P2_END: begin
            next_r.minor = r.flash_blk; // [R17]
            next_r.relay = 3'b010;
          end
          default: begin
            next_r.minor = r.fast_blk;
          end
        endcase
      end
      default: begin
        next_r.minor = 1'b0;
      end
    endcase

    // Sticky events; a new event wins over a clear in the same cycle
    // The interrupt is taken from the next status so that it rises
    // in the same cycle as the status bit it reports
    if (wr_en) begin
      next_r.irq_en = I_WDATA[`OMS_IRQ_W-1:0];
    end
    next_r.irq_stat = r.irq_stat;
    if (wr_clr) begin
      next_r.irq_stat = r.irq_stat & ~I_WDATA[`OMS_IRQ_W-1:0];
    end
    next_r.irq_stat = next_r.irq_stat | evt;
    next_r.irq      = |(next_r.irq_stat & next_r.irq_en);

    // Read data stands only in the cycle after the strobe
    next_r.rdata = 32'h00000000;
    if (I_RD) begin
      case (I_ADDR)
        `OMS_REG_MODE:     next_r.rdata = {30'h00000000, r.mode};
        `OMS_REG_STATUS:   next_r.rdata = {16'h0000, r.ao_a == r.ao_b,
                                           r.diag_started, r.hold_wait,
                                           r.liq, r.noise, r.serious,
                                           r.minor, r.relay,
                                           r.seq, r.mode};
        `OMS_REG_IRQ_STAT: next_r.rdata = {27'h0000000, r.irq_stat};
        `OMS_REG_IRQ_EN:   next_r.rdata = {27'h0000000, r.irq_en};
        `OMS_REG_AO:       next_r.rdata = {r.ao_b, r.ao_a};
        default:           next_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      // Analog outputs rest at live zero during reset, so the loop
      // never reads as a broken wire while the block restarts
      r      <= '0;
      r.ao_a <= `OMS_AO_ZERO;
      r.ao_b <= `OMS_AO_ZERO;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    O_RDATA                   = r.rdata;
    O_RELAY                   = r.relay;
    O_MINOR_FAILURE_OUTPUT    = r.minor;
    O_SERIOUS_FAILURE_OUTPUT  = r.serious;
    O_NOISE_PROTECTION_OUTPUT = r.noise;
    O_LIQUEFACTION_OUTPUT     = r.liq;
    O_ANALOG_OUTPUT_A         = r.ao_a;
    O_ANALOG_OUTPUT_B         = r.ao_b;
    O_ACCEL_DIAG_START        = r.diag_start;
    O_IRQ                     = r.irq;
  end

endmodule

/* src/oms_regs.svh */
// Register offsets, field positions, codes and timing constants
`ifndef OMS_REGS_SVH
`define OMS_REGS_SVH

`define OMS_ADDR_W        8
`define OMS_AO_W          16

// Register byte offsets
`define OMS_REG_MODE      8'h00
`define OMS_REG_REQ       8'h04
`define OMS_REG_STATUS    8'h08
`define OMS_REG_IRQ_STAT  8'h0C
`define OMS_REG_IRQ_CLR   8'h10
`define OMS_REG_IRQ_EN    8'h14
`define OMS_REG_AO        8'h18

// Request register bits (write-one pulses)
`define OMS_REQ_MODE_BIT  0
`define OMS_REQ_PHASE_BIT 1

// Interrupt event bits
`define OMS_IRQ_W         5
`define OMS_IRQ_MAINT     0
`define OMS_IRQ_PHASE2    1
`define OMS_IRQ_STEP_DONE 2
`define OMS_IRQ_DIAG      3
`define OMS_IRQ_SERIOUS   4

// Analog output codes in microamperes
`define OMS_AO_FULL       16'h4E20
`define OMS_AO_HALF       16'h2EE0
`define OMS_AO_ZERO       16'h0FA0
`define OMS_AO_FAULT      16'h0DAC

// Clock and time base
`define OMS_CLK_MHZ       250
`define OMS_TICK_US       1000
`define OMS_TICK_CYC      (`OMS_CLK_MHZ * `OMS_TICK_US)

// Times in milliseconds
`define OMS_T_HOLD_MS     2000
`define OMS_T_STEP_MS     1000
`define OMS_T_DIAG_MS     30000
`define OMS_T_P2_RUN_MS   28000
`define OMS_T_FAST_MS     500
`define OMS_T_SLOW_MS     100
`define OMS_T_MSLOW_MS    500
`define OMS_T_FLASH_MS    250

`endif

/* src/oms_pkg.sv */
// Types for the output mode and maintenance sequencer
package oms_pkg;

  typedef enum logic [1:0] {
    MODE_INIT    = 2'b00,
    MODE_MEAS    = 2'b01,
    MODE_STANDBY = 2'b10,
    MODE_MAINT   = 2'b11
  } oms_mode_t;

  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0000,
    SEQ_P1_A   = 4'b0001,
    SEQ_P1_B   = 4'b0010,
    SEQ_P1_C   = 4'b0011,
    SEQ_P1_END = 4'b0100,
    SEQ_P2_A   = 4'b0101,
    SEQ_P2_B   = 4'b0110,
    SEQ_P2_C   = 4'b0111,
    SEQ_P2_END = 4'b1000
  } oms_seq_t;

  typedef struct packed {
    oms_mode_t   mode;
    oms_seq_t    seq;
    logic [19:0] tick_cnt;
    logic        tick;
    logic [15:0] hold_ms;
    logic        hold_wait;
    logic [15:0] step_ms;
    logic [15:0] maint_ms;
    logic        diag_started;
    logic [15:0] fast_ms;
    logic [15:0] slow_ms;
    logic [15:0] mslow_ms;
    logic [15:0] flash_ms;
    logic        fast_blk;
    logic        slow_blk;
    logic        mslow_blk;
    logic        flash_blk;
    logic        serious_d;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_en;
    logic [2:0]  relay;
    logic        minor;
    logic        serious;
    logic        noise;
    logic        liq;
    logic [15:0] ao_a;
    logic [15:0] ao_b;
    logic        diag_start;
    logic        irq;
    logic [31:0] rdata;
  } oms_state_t;

endpackage

/* dv/oms_assertions.sv */
// Port-level checker for the output mode and maintenance sequencer
`include "oms_regs.svh"

module oms_chk (
  input wire logic                 I_CLK_SYS,
  input wire logic                 I_RST,
  input wire logic                 I_SERIOUS_FAIL,
  input wire logic                 I_NOISE_ACTIVE,
  input wire logic [2:0]           O_RELAY,
  input wire logic                 O_SERIOUS_FAILURE_OUTPUT,
  input wire logic                 O_NOISE_PROTECTION_OUTPUT,
  input wire logic                 O_LIQUEFACTION_OUTPUT,
  input wire logic [`OMS_AO_W-1:0] O_ANALOG_OUTPUT_A,
  input wire logic [`OMS_AO_W-1:0] O_ANALOG_OUTPUT_B,
  input wire logic                 O_ACCEL_DIAG_START
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  // Fault code only appears one edge after the failure input
  property p_fault;
    O_ANALOG_OUTPUT_A == `OMS_AO_FAULT |-> $past(I_SERIOUS_FAIL)
      && O_RELAY == 3'h0 && O_SERIOUS_FAILURE_OUTPUT
      && !O_NOISE_PROTECTION_OUTPUT && O_ANALOG_OUTPUT_B == `OMS_AO_FAULT;
  endproperty
  a_fault: assert property (p_fault)
    else $error("serious failure outputs wrong");
  property p_noise;
    O_NOISE_PROTECTION_OUTPUT |-> !O_SERIOUS_FAILURE_OUTPUT
      && $past(I_NOISE_ACTIVE);
  endproperty
  a_noise: assert property (p_noise)
    else $error("noise output without noise state");
  property p_p1_out;
    O_ANALOG_OUTPUT_A == `OMS_AO_FULL |->
      O_ANALOG_OUTPUT_B == `OMS_AO_FULL && O_RELAY[2:1] == 2'h0;
  endproperty
  a_p1_out: assert property (p_p1_out)
    else $error("phase one outputs wrong");
  property p_p1_serious;
    $rose(O_ANALOG_OUTPUT_A == `OMS_AO_FULL) |->
      !O_SERIOUS_FAILURE_OUTPUT [*4] ##[1:20] O_SERIOUS_FAILURE_OUTPUT;
  endproperty
  a_p1_serious: assert property (p_p1_serious)
    else $error("phase one serious step timing");
  property p_p1_relay;
    $rose(O_SERIOUS_FAILURE_OUTPUT) && O_ANALOG_OUTPUT_A == `OMS_AO_FULL
      |-> !O_RELAY[0] [*4] ##[1:20] O_RELAY[0];
  endproperty
  a_p1_relay: assert property (p_p1_relay)
    else $error("phase one relay step timing");
  property p_diag_early;
    $rose(O_ANALOG_OUTPUT_A == `OMS_AO_FULL) |-> !O_ACCEL_DIAG_START [*8];
  endproperty
  a_diag_early: assert property (p_diag_early)
    else $error("diagnosis started too early");
  property p_diag_pulse;
    O_ACCEL_DIAG_START |=> !O_ACCEL_DIAG_START;
  endproperty
  a_diag_pulse: assert property (p_diag_pulse)
    else $error("diagnosis start longer than one cycle");
  property p_liq;
    O_LIQUEFACTION_OUTPUT |-> O_ANALOG_OUTPUT_A == `OMS_AO_ZERO
      && O_RELAY[0] && !O_SERIOUS_FAILURE_OUTPUT;
  endproperty
  a_liq: assert property (p_liq)
    else $error("liquefaction blink outside diagnosis done");
  property p_p2_out;
    O_ANALOG_OUTPUT_A == `OMS_AO_HALF |-> !O_RELAY[0]
      && !O_LIQUEFACTION_OUTPUT && O_ANALOG_OUTPUT_B == `OMS_AO_HALF;
  endproperty
  a_p2_out: assert property (p_p2_out)
    else $error("phase two outputs wrong");
  property p_p2_serious;
    $rose(O_ANALOG_OUTPUT_A == `OMS_AO_HALF) |->
      !O_SERIOUS_FAILURE_OUTPUT [*4] ##[1:20] O_SERIOUS_FAILURE_OUTPUT;
  endproperty
  a_p2_serious: assert property (p_p2_serious)
    else $error("phase two serious step timing");
  property p_p2_relay;
    $rose(O_SERIOUS_FAILURE_OUTPUT) && O_ANALOG_OUTPUT_A == `OMS_AO_HALF
      |-> !O_RELAY[1] [*4] ##[1:20] O_RELAY[1];
  endproperty
  a_p2_relay: assert property (p_p2_relay)
    else $error("phase two relay step timing");
  property p_p2_end;
    $fell(O_ANALOG_OUTPUT_A == `OMS_AO_HALF) |-> O_RELAY[1]
      && !O_SERIOUS_FAILURE_OUTPUT && O_ANALOG_OUTPUT_B == `OMS_AO_ZERO;
  endproperty
  a_p2_end: assert property (p_p2_end)
    else $error("phase two end outputs wrong");
endmodule

bind oms_top oms_chk u_chk (
  .I_CLK_SYS                 (I_CLK_SYS),
  .I_RST                     (I_RST),
  .I_SERIOUS_FAIL            (I_SERIOUS_FAIL),
  .I_NOISE_ACTIVE            (I_NOISE_ACTIVE),
  .O_RELAY                   (O_RELAY),
  .O_SERIOUS_FAILURE_OUTPUT  (O_SERIOUS_FAILURE_OUTPUT),
  .O_NOISE_PROTECTION_OUTPUT (O_NOISE_PROTECTION_OUTPUT),
  .O_LIQUEFACTION_OUTPUT     (O_LIQUEFACTION_OUTPUT),
  .O_ANALOG_OUTPUT_A         (O_ANALOG_OUTPUT_A),
  .O_ANALOG_OUTPUT_B         (O_ANALOG_OUTPUT_B),
  .O_ACCEL_DIAG_START        (O_ACCEL_DIAG_START)
);

/* dv/oms_plant.sv */
// Plant-side model that holds the diagnosis input
module oms_plant (
  input  wire logic clk,
  output logic      diag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial diag = 1'b0;
  // Plant keeps the level steady for the whole press
  task automatic hold_diag(input int n);
    @(posedge clk);
    diag <= 1'b1;
    repeat (n) @(posedge clk);
    diag <= 1'b0;
  endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the output mode and maintenance sequencer
`include "oms_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [31:0] rdata;
  logic        diag;
  logic        minor_f;
  logic        serious_f;
  logic        noise_act;
  logic [2:0]  hold_rl;
  logic [2:0]  noise_rl;
  logic [15:0] pv_a;
  logic [15:0] pv_b;
  logic        done = 1'b0;
  logic [2:0]  relay;
  logic        minor, serious, noise, liq, dstart, irq;
  logic [15:0] ao_a, ao_b;
  int          bad_count = 0;
  int          n_compared = 0;

  always #2 clk = ~clk;

  oms_plant u_plant (.clk(clk), .diag(diag));

  // Short counts keep the run near a thousand cycles
  oms_top #(.TICK_CYCLES(4), .HOLD_MS(3), .STEP_MS(2), .DIAG_MS(10),
    .P2_RUN_MS(5), .FAST_HALF_MS(3), .SLOW_HALF_MS(2),
    .MSLOW_HALF_MS(3), .FLASH_HALF_MS(2)) u_dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_DIAGNOSIS_INPUT(diag),
    .I_MINOR_FAIL(minor_f), .I_SERIOUS_FAIL(serious_f),
    .I_NOISE_ACTIVE(noise_act), .I_HOLD_RELAY(hold_rl),
    .I_NOISE_RELAY(noise_rl), .I_PV_A(pv_a), .I_PV_B(pv_b),
    .I_ACCEL_DIAG_DONE(done), .O_RELAY(relay),
    .O_MINOR_FAILURE_OUTPUT(minor), .O_SERIOUS_FAILURE_OUTPUT(serious),
    .O_NOISE_PROTECTION_OUTPUT(noise), .O_LIQUEFACTION_OUTPUT(liq),
    .O_ANALOG_OUTPUT_A(ao_a), .O_ANALOG_OUTPUT_B(ao_b),
    .O_ACCEL_DIAG_START(dstart), .O_IRQ(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic set_pv(input logic [15:0] a, input logic [15:0] b);
    pv_a <= a;
    pv_b <= b;
  endtask

  task automatic set_rl(input logic [2:0] h, input logic [2:0] n);
    hold_rl <= h;
    noise_rl <= n;
  endtask

  // Bits are the serious, noise and minor failure states
  task automatic set_st(input logic [2:0] s);
    {serious_f, noise_act, minor_f} <= s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic wait_ao(input logic [15:0] v);
    repeat (300) if (ao_a !== v) step(1);
    chk({ao_b, ao_a}, {v, v});
  endtask

  // Counts minor or liquefaction edges; one edge of slack for the tick
  task automatic blink(input int half_ms, input bit use_liq = 1'b0);
    int t;
    int e;
    logic p;
    t = 0;
    e = 96 / (half_ms * 4);
    p = use_liq ? liq : minor;
    repeat (96) begin
      step(1);
      if ((use_liq ? liq : minor) !== p) t++;
      p = use_liq ? liq : minor;
    end
    chk(32'(t >= e - 1 && t <= e + 1), 32'd1);
  endtask

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    bad_count++;
    end_sim();
  end

  initial begin
    set_pv(16'h1234, 16'h2345);
    set_rl(3'h5, 3'h2);
    set_st(3'b000);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk({relay, serious, noise, liq}, 6'h00);
    chk(ao_a, `OMS_AO_ZERO);
    blink(3);
    $display("init test done");
    wr(`OMS_REG_MODE, 32'h1);
    wr(`OMS_REG_IRQ_EN, 32'h11);
    step(4);
    chk({ao_b, ao_a}, {16'h2345, 16'h1234});
    chk({relay, minor}, 4'hA);
    set_st(3'b010);
    step(4);
    chk({noise, relay}, 4'hA);
    set_rl(3'h5, 3'h4);
    step(4);
    chk({noise, relay}, 4'hC);
    set_st(3'b001);
    step(4);
    chk(minor, 1'b1);
    set_st(3'b111);
    step(4);
    chk({relay, serious, noise}, 5'h02);
    wait_ao(`OMS_AO_FAULT);
    chk(irq, 1'b1);
    set_st(3'b000);
    rd(`OMS_REG_IRQ_STAT, 32'h10);
    wr(`OMS_REG_IRQ_CLR, 32'h10);
    step(2);
    chk(irq, 1'b0);
    rd(8'h1C, 32'h0);
    $display("measurement test done");
    wr(`OMS_REG_MODE, 32'h2);
    step(4);
    chk(relay, 3'h5);
    blink(2);
    wr(`OMS_REG_MODE, 32'h1);
    set_rl(3'h7, 3'h4);
    set_pv(16'h0BCD, 16'h3456);
    u_plant.hold_diag(6);
    step(20);
    chk({ao_b, ao_a}, {16'h3456, 16'h0BCD});
    chk(relay, 3'h7);
    u_plant.hold_diag(24);
    wait_ao(`OMS_AO_FULL);
    chk(irq, 1'b1);
    repeat (60) if (!serious) step(1);
    chk(serious, 1'b1);
    repeat (60) if (!relay[0]) step(1);
    chk(relay, 3'h1);
    // A done pulse before the diagnosis has started must be ignored
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    repeat (80) if (!dstart) step(1);
    chk(dstart, 1'b1);
    chk(ao_a, `OMS_AO_FULL);
    rd(`OMS_REG_AO, {`OMS_AO_FULL, `OMS_AO_FULL});
    blink(3);
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    wait_ao(`OMS_AO_ZERO);
    chk({relay, serious}, 4'h2);
    blink(2);
    blink(3, 1'b1);
    $display("phase one test done");
    wr(`OMS_REG_REQ, 32'h2);
    wait_ao(`OMS_AO_HALF);
    chk({liq, relay[0]}, 2'h0);
    repeat (60) if (!serious) step(1);
    chk(serious, 1'b1);
    repeat (60) if (!relay[1]) step(1);
    chk(relay[1], 1'b1);
    wait_ao(`OMS_AO_ZERO);
    chk({relay[1], serious}, 2'h2);
    blink(2);
    wr(`OMS_REG_REQ, 32'h1);
    step(4);
    rd(`OMS_REG_MODE, 32'h0);
    rd(`OMS_REG_IRQ_STAT, 32'h0F);
    blink(3);
    $display("phase two test done");
    end_sim();
  end
endmodule
